// *** inc/crs_params.svh ***
// Constants for the control-register target: offsets, fields, codes
`ifndef CRS_PARAMS_SVH
`define CRS_PARAMS_SVH

// Register map, one byte per location
`define CRS_ADDR_MCTRL 8'h00
`define CRS_ADDR_SN_FIRST 8'h01
`define CRS_ADDR_SN_LAST 8'h08
`define CRS_ADDR_ID_FIRST 8'h09
`define CRS_ADDR_ID_LAST 8'h0c
`define CRS_ADDR_CMD 8'haa

// Reset values
`define CRS_SN_RESET 8'h00
`define CRS_MCTRL_RESET 8'h00

// Memory control bit positions
`define CRS_LOCK_BIT 0
`define CRS_AUTOSAVE_BIT 1

// Command byte that requests a save; value is arbitrary
`define CRS_CMD_SAVE 8'h3c

// Bus device address of this target; value is arbitrary
`define CRS_DEV_ADDR 7'h32

// Identification word field positions
`define CRS_MAKER_MSB 31
`define CRS_MAKER_LSB 21
`define CRS_PART_MSB 20
`define CRS_PART_LSB 7
`define CRS_CAP_MSB 6
`define CRS_CAP_LSB 3
`define CRS_REV_MSB 2
`define CRS_REV_LSB 0

// Identification field values; all values are arbitrary
`define CRS_MAKER_BANK 3'h5
`define CRS_MAKER_CODE 8'h5a
`define CRS_PART_CODE 14'h0123
`define CRS_CAP_CODE 4'h2
`define CRS_REV_CODE 3'h2

// Bit slot counts within one byte on the link
`define CRS_SLOT_LAST_BIT 4'd7
`define CRS_SLOT_ACK 4'd8

`endif

// *** inc/crs_pkg.sv ***
// Types shared by the control-register target
package crs_pkg;

  typedef enum logic [2:0] {
    CRS_ST_IDLE = 3'b000,
    CRS_ST_DEV = 3'b001,
    CRS_ST_REG = 3'b010,
    CRS_ST_WR = 3'b011,
    CRS_ST_RD = 3'b100,
    CRS_ST_DROP = 3'b101
  } crs_link_st_t;

endpackage

// *** design/crs_ctrl_target.sv ***
// Control-register target: serial number, lock, id word, command byte
//
// Functional notes
// - Serial number lives at bytes 0x01..0x08, written over the bus.
// - Each serial byte resets to 0x00 until written.
// - Serial bytes stored verbatim; no checksum computed or checked.
// - Serial bytes become nonvolatile only at the next save.
// - Power-down saves when autosave enabled; else master commands save.
// - Unlocked serial bytes may be rewritten at any time.
// - Locked serial bytes answer data with NACK and stay unchanged.
// - Memory control and serial saved on next save, commanded or auto.
// - Without a save, lock bit and serial bytes come up zero.
// - Serial reads return last written values, locked or not.
// - Burst reads wrap from last readable location back to 0x00.
// - 32-bit id word: maker, part, capacity and revision fields.
// - Id word fixed at build time, read only.
// - Maker field: upper three bits bank, lower eight bits code.
// - Command byte written to 0xaa starts the device command.
// - While a command runs, every target answers NACK.
// - Unknown command bytes are acknowledged and do nothing.
// - After a command write the address counter rolls to 0x00.
// - Command register write only; reads starting there wrap to 0x00.
// - With lock set only 0x00 and 0xaa accept writes.
// - Non-writable write: NACK, ignore rest, counter unchanged.
`timescale 1ns/1ps
`include "crs_params.svh"

module crs_ctrl_target (
  input wire logic clock,
  input wire logic reset,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic power_fail,
  input wire logic save_done,
  output logic save_req,
  output logic target_busy,
  output logic [63:0] serial_number,
  output logic [7:0] memory_control,
  output logic serial_lock_bit
);

  // ---------------- Main clock domain state ----------------
  logic [7:0] mctrl_q;
  logic [7:0] serial_q [0:7];
  logic save_req_q;
  logic wr_s1_q;
  logic wr_s2_q;
  logic wr_s3_q;
  logic pf_s1_q;
  logic pf_s2_q;
  logic pf_s3_q;
  logic wr_ev;
  logic pf_rise;
  logic lock;
  logic [31:0] id_word;

  // ---------------- Link clock domain state ----------------
  crs_pkg::crs_link_st_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] sr_q;
  logic [7:0] ptr_q;
  logic [7:0] rd_byte_q;
  logic ack_q;
  logic start_t_q;
  logic seen_q;
  logic busy_s1_q;
  logic busy_s2_q;
  logic wr_tog_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic sda_low_q;
  logic [7:0] byte_in;
  logic start_pend;
  logic [7:0] ptr_rd;

  // Identification word, fixed at build time
  // field packing
  assign id_word = {`CRS_MAKER_BANK, `CRS_MAKER_CODE, `CRS_PART_CODE,
                    `CRS_CAP_CODE, `CRS_REV_CODE};

  assign lock = mctrl_q[`CRS_LOCK_BIT];

  // True for any location a read may return
  function automatic logic readable(input logic [7:0] a);
    readable = (a <= `CRS_ADDR_ID_LAST);
  endfunction

  // True for any location a register-address byte may select
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = readable(a) || (a == `CRS_ADDR_CMD);
  endfunction

  // Write permission for one location under the lock state
  function automatic logic wr_ok(input logic [7:0] a, input logic lk);
    logic sn;
    sn = (a >= `CRS_ADDR_SN_FIRST) && (a <= `CRS_ADDR_SN_LAST);
    wr_ok = (a == `CRS_ADDR_MCTRL) || (a == `CRS_ADDR_CMD) || (sn && !lk);
  endfunction

  // Read data mux over the readable map
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a == `CRS_ADDR_MCTRL) begin
      r = mctrl_q;
    end else if (a <= `CRS_ADDR_SN_LAST) begin
      r = serial_q[3'(a - `CRS_ADDR_SN_FIRST)];
    end else begin
      case (a)
        8'h09: r = id_word[31:24];
        8'h0a: r = id_word[23:16];
        8'h0b: r = id_word[15:8];
        8'h0c: r = id_word[7:0];
        default: r = 8'h00;
      endcase
    end
    rd_mux = r;
  endfunction

  // =================== Link clock domain ===================
  // The link clock stops between frames, so this domain takes the
  // chip reset asynchronously; it is released while the bus is idle.

  // Start condition: data falls while the link clock is high
  always_ff @(negedge sda_in or posedge reset) begin
    if (reset) begin
      start_t_q <= 1'b0;
    end else if (scl_clk) begin
      start_t_q <= ~start_t_q;
    end
  end

  // Start toggle is stable a full hold time before the next rising edge
  always_ff @(posedge scl_clk or posedge reset) begin
    if (reset) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= start_t_q;
    end
  end

  assign start_pend = start_t_q ^ seen_q;
  assign byte_in = {sr_q[6:0], sda_in};

  // Out-of-range pointers, including the command address, read location 0x00
  // command address wraps
  assign ptr_rd = readable(ptr_q) ? ptr_q : `CRS_ADDR_MCTRL;

  // Busy level into the link domain; updates during the address bits
  always_ff @(posedge scl_clk or posedge reset) begin
    if (reset) begin
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
    end else begin
      busy_s1_q <= save_req_q;
      busy_s2_q <= busy_s1_q;
    end
  end

  // Byte framing, address decode, acknowledge and pointer handling
  always_ff @(posedge scl_clk or posedge reset) begin
    if (reset) begin
      st_q <= crs_pkg::CRS_ST_IDLE;
      cnt_q <= 4'h0;
      sr_q <= 8'h00;
      ptr_q <= 8'h00;
      rd_byte_q <= 8'h00;
      ack_q <= 1'b0;
      wr_tog_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else if (start_pend) begin
      // First address bit of a new frame, repeated start included
      st_q <= crs_pkg::CRS_ST_DEV;
      cnt_q <= 4'h1;
      sr_q <= {7'h00, sda_in};
      ack_q <= 1'b0;
    end else begin
      case (st_q)
        crs_pkg::CRS_ST_IDLE, crs_pkg::CRS_ST_DROP: begin
          ack_q <= 1'b0;
        end
        default: begin
          if (cnt_q == `CRS_SLOT_ACK) begin
            cnt_q <= 4'h0;
            ack_q <= 1'b0;
            if (st_q == crs_pkg::CRS_ST_RD) begin
              if (sda_in) begin
                // Master declined further bytes
                st_q <= crs_pkg::CRS_ST_DROP;
              end else begin
                rd_byte_q <= rd_mux(ptr_rd);
                ptr_q <= (ptr_rd == `CRS_ADDR_ID_LAST) ?
                         `CRS_ADDR_MCTRL : ptr_rd + 8'h01;
              end
            end
          end else begin
            cnt_q <= cnt_q + 4'h1;
            sr_q <= byte_in;
            if (cnt_q == `CRS_SLOT_LAST_BIT) begin
              case (st_q)
                crs_pkg::CRS_ST_DEV: begin
                  if (byte_in[7:1] == `CRS_DEV_ADDR && !busy_s2_q) begin
                    ack_q <= 1'b1;
                    st_q <= byte_in[0] ? crs_pkg::CRS_ST_RD
                                       : crs_pkg::CRS_ST_REG;
                  end else begin
                    st_q <= crs_pkg::CRS_ST_DROP;
                  end
                end
                crs_pkg::CRS_ST_REG: begin
                  // Out-of-range address byte is refused at once
                  if (addr_ok(byte_in)) begin
                    ptr_q <= byte_in;
                    ack_q <= 1'b1;
                    st_q <= crs_pkg::CRS_ST_WR;
                  end else begin
                    st_q <= crs_pkg::CRS_ST_DROP;
                  end
                end
                crs_pkg::CRS_ST_WR: begin
                  if (wr_ok(ptr_q, lock)) begin
                    ack_q <= 1'b1;
                    wr_addr_q <= ptr_q;
                    wr_data_q <= byte_in;
                    wr_tog_q <= ~wr_tog_q;
                    if (ptr_q == `CRS_ADDR_CMD) begin
                      ptr_q <= `CRS_ADDR_MCTRL;
                      st_q <= crs_pkg::CRS_ST_DROP;
                    end else begin
                      ptr_q <= ptr_q + 8'h01;
                    end
                  end else begin
                    st_q <= crs_pkg::CRS_ST_DROP;
                  end
                end
                default: begin
                  ack_q <= 1'b0;
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  // Drive the data line on the falling edge: acknowledge or read bits
  always_ff @(negedge scl_clk or posedge reset) begin
    if (reset) begin
      sda_low_q <= 1'b0;
    end else if (cnt_q == `CRS_SLOT_ACK) begin
      sda_low_q <= ack_q;
    end else if (st_q == crs_pkg::CRS_ST_RD && !start_pend) begin
      sda_low_q <= ~rd_byte_q[3'(`CRS_SLOT_LAST_BIT - cnt_q)];
    end else begin
      sda_low_q <= 1'b0;
    end
  end

  // Open-drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe_n = ~sda_low_q;

  // =================== Main clock domain ===================

  // Write event toggle crossing; address and data settle long before
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_s1_q <= 1'b0;
      wr_s2_q <= 1'b0;
      wr_s3_q <= 1'b0;
    end else begin
      wr_s1_q <= wr_tog_q;
      wr_s2_q <= wr_s1_q;
      wr_s3_q <= wr_s2_q;
    end
  end

  assign wr_ev = wr_s2_q ^ wr_s3_q;

  // Power-fail pin synchroniser and rising-edge detect
  always_ff @(posedge clock) begin
    if (reset) begin
      pf_s1_q <= 1'b0;
      pf_s2_q <= 1'b0;
      pf_s3_q <= 1'b0;
    end else begin
      pf_s1_q <= power_fail;
      pf_s2_q <= pf_s1_q;
      pf_s3_q <= pf_s2_q;
    end
  end

  assign pf_rise = pf_s2_q & ~pf_s3_q;

  // Memory control register, holds the lock bit
  // zero at power-up
  always_ff @(posedge clock) begin
    if (reset) begin
      mctrl_q <= `CRS_MCTRL_RESET;
    end else if (wr_ev && wr_addr_q == `CRS_ADDR_MCTRL) begin
      mctrl_q <= wr_data_q;
    end
  end

  // Serial number bytes, stored exactly as written
  // reset to 0x00
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < 8; i++) begin
        serial_q[i] <= `CRS_SN_RESET;
      end
    end else if (wr_ev && wr_addr_q >= `CRS_ADDR_SN_FIRST &&
                 wr_addr_q <= `CRS_ADDR_SN_LAST) begin
      serial_q[3'(wr_addr_q - `CRS_ADDR_SN_FIRST)] <= wr_data_q;
    end
  end

  // Save request toward the nonvolatile engine; a new request wins
  // over a completion seen in the same cycle
  // command executed
  always_ff @(posedge clock) begin
    if (reset) begin
      save_req_q <= 1'b0;
    end else if ((wr_ev && wr_addr_q == `CRS_ADDR_CMD &&
                  wr_data_q == `CRS_CMD_SAVE) ||
                 (pf_rise && mctrl_q[`CRS_AUTOSAVE_BIT])) begin
      save_req_q <= 1'b1;
    end else if (save_done) begin
      save_req_q <= 1'b0;
    end
  end

  // Image presented to the engine; saved only when it acts
  // nonvolatile at next save
  always_ff @(posedge clock) begin
    if (reset) begin
      serial_number <= 64'h0;
      memory_control <= 8'h00;
    end else begin
      serial_number <= {serial_q[7], serial_q[6], serial_q[5], serial_q[4],
                        serial_q[3], serial_q[2], serial_q[1], serial_q[0]};
      memory_control <= mctrl_q;
    end
  end

  assign save_req = save_req_q;
  assign target_busy = save_req_q;
  assign serial_lock_bit = lock;

endmodule

// *** verification/crs_i2c_mst.sv ***
// Bus master model: drives the link clock and the data line
`timescale 1ns/1ps
module crs_i2c_mst (
  output logic scl_clk,
  output logic sda_drv,
  input logic sda_in
);
  localparam realtime HALF = 62.5;
  localparam realtime QTR = 31.25;
  // Clock and data rest high between frames
  initial begin
    scl_clk = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic start();
    #QTR sda_drv = 1'b1;
    #QTR scl_clk = 1'b1;
    #HALF sda_drv = 1'b0;
    #HALF scl_clk = 1'b0;
  endtask
  // One bit slot: data moves while clock low, sampled at the rise
  task automatic slot(input logic b, output logic s);
    #QTR sda_drv = b;
    #QTR scl_clk = 1'b1;
    s = sda_in;
    #HALF scl_clk = 1'b0;
  endtask
  // Byte out, most significant bit first, then the answer slot
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) slot(b[i], s);
    slot(1'b1, s);
    ack = ~s;
  endtask
  // Byte in, then our own acknowledge
  task automatic rbyte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      slot(1'b1, s);
      b[i] = s;
    end
    slot(~mack, s);
  endtask
  // Stop: data rises while clock high
  task automatic stop();
    #QTR sda_drv = 1'b0;
    #QTR scl_clk = 1'b1;
    #HALF sda_drv = 1'b1;
    #HALF;
  endtask
endmodule

// *** verification/crs_ctrl_target_properties.sv ***
// Port checker for the control-register target
`timescale 1ns/1ps
module crs_ctrl_target_props (
  input logic clock,
  input logic reset,
  input logic scl_clk,
  input logic sda_oe_n,
  input logic power_fail,
  input logic save_done,
  input logic save_req,
  input logic target_busy,
  input logic [63:0] serial_number,
  input logic [7:0] memory_control,
  input logic serial_lock_bit
);
  property p_busy_eq;
    @(posedge clock) disable iff (reset) target_busy == save_req;
  endproperty
  a_busy_eq: assert property (p_busy_eq)
    else $error("busy differs from save request");
  property p_req_hold;
    @(posedge clock) disable iff (reset)
      save_req && !save_done |=> save_req;
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("save request dropped early");
  property p_sn_reset;
    @(posedge clock) disable iff (reset)
      $fell(reset) |-> serial_number == 64'h0 && memory_control == 8'h00;
  endproperty
  a_sn_reset: assert property (p_sn_reset)
    else $error("registers not clear after reset");
  property p_lock_map;
    @(posedge clock) disable iff (reset)
      memory_control[0] == $past(serial_lock_bit);
  endproperty
  a_lock_map: assert property (p_lock_map)
    else $error("lock image wrong");
  property p_sn_locked;
    @(posedge clock) disable iff (reset)
      !$stable(serial_number) |-> !$past(serial_lock_bit, 8);
  endproperty
  a_sn_locked: assert property (p_sn_locked)
    else $error("serial changed while locked");
  property p_busy_nack;
    @(posedge scl_clk) disable iff (reset)
      target_busy && $past(target_busy, 3) |-> sda_oe_n;
  endproperty
  a_busy_nack: assert property (p_busy_nack)
    else $error("wire pulled while busy");
  property p_pf_save;
    @(posedge clock) disable iff (reset)
      $rose(power_fail) && memory_control[1] |-> ##[1:5] save_req;
  endproperty
  a_pf_save: assert property (p_pf_save)
    else $error("no save at power loss");
  property p_pf_off;
    @(posedge clock) disable iff (reset)
      $rose(power_fail) && !memory_control[1] && !save_req
        |-> !save_req [*5];
  endproperty
  a_pf_off: assert property (p_pf_off)
    else $error("save without autosave enabled");
endmodule

bind crs_ctrl_target crs_ctrl_target_props u_props (
  .clock(clock), .reset(reset), .scl_clk(scl_clk), .sda_oe_n(sda_oe_n),
  .power_fail(power_fail), .save_done(save_done), .save_req(save_req),
  .target_busy(target_busy), .serial_number(serial_number),
  .memory_control(memory_control), .serial_lock_bit(serial_lock_bit));

// *** verification/crs_ctrl_target_tb.sv ***
// Self-checking bench for the control-register target
`timescale 1ns/1ps
`include "crs_params.svh"
module crs_ctrl_target_tb;
  logic clock, reset, power_fail, save_done, eng_en, ack;
  logic scl_clk, sda_drv, sda_in, sda_out, sda_oe_n;
  logic save_req, target_busy, serial_lock_bit;
  logic [63:0] serial_number, sn_exp;
  logic [7:0] memory_control, q[$];
  logic [31:0] id_exp;
  int miscompares, total_checks;
  // Open-drain wire with pull-up
  assign sda_in = sda_drv & (sda_oe_n | sda_out);
  crs_ctrl_target u_dut (
    .clock(clock), .reset(reset), .scl_clk(scl_clk), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .power_fail(power_fail),
    .save_done(save_done), .save_req(save_req), .target_busy(target_busy),
    .serial_number(serial_number), .memory_control(memory_control),
    .serial_lock_bit(serial_lock_bit));
  crs_i2c_mst u_mst (.scl_clk(scl_clk), .sda_drv(sda_drv), .sda_in(sda_in));
  // Main clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Save engine finishes while enabled
  always @(negedge clock) save_done <= save_req & eng_en;
  // Compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Start and address the target
  task automatic sel(input logic rw, input logic exp_ack);
    u_mst.start();
    u_mst.wbyte({`CRS_DEV_ADDR, rw}, ack);
    chk(ack, exp_ack);
  endtask
  task automatic fin();
    u_mst.stop();
    repeat (10) @(negedge clock);
  endtask
  // Set the register pointer, frame left open
  task automatic pt(input logic [7:0] a, input logic exp_ack);
    sel(1'b0, 1'b1);
    u_mst.wbyte(a, ack);
    chk(ack, exp_ack);
  endtask
  // Write frame; the first n_ok data bytes expect ACK
  task automatic wr(input logic [7:0] a, input logic [7:0] d[$],
    input int n_ok);
    pt(a, 1'b1);
    foreach (d[i]) begin
      u_mst.wbyte(d[i], ack);
      chk(ack, i < n_ok);
    end
    fin();
  endtask
  // Read frame from the current pointer
  task automatic rd(input logic [7:0] e[$]);
    logic [7:0] b;
    sel(1'b1, 1'b1);
    foreach (e[i]) begin
      u_mst.rbyte(i < e.size() - 1, b);
      chk(b, e[i]);
    end
    fin();
  endtask
  task automatic wait_req(input logic lvl);
    int n;
    n = 0;
    while (save_req !== lvl && n < 100) begin
      @(negedge clock);
      n++;
    end
    chk(save_req, lvl);
    // Bound used up without the level: end the run
    if (save_req !== lvl) results();
  endtask
  // Main sequence
  initial begin
    // A clean rising edge so the link-side flops see the reset
    reset = 1'b0;
    power_fail = 1'b0;
    eng_en = 1'b0;
    #1 reset = 1'b1;
    miscompares = 0;
    total_checks = 0;
    id_exp = {`CRS_MAKER_BANK, `CRS_MAKER_CODE, `CRS_PART_CODE,
      `CRS_CAP_CODE, `CRS_REV_CODE};
    repeat (6) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
    chk({save_req, serial_lock_bit, memory_control}, 0);
    chk(serial_number, 0);
    chk({sda_out, ~sda_oe_n}, 0);
    for (int k = 0; k < 8; k++) begin
      q.push_back(8'hf7 - 8'(k * 37));
      sn_exp[8*k +: 8] = q[k];
    end
    wr(`CRS_ADDR_SN_FIRST, q, 8);
    chk(serial_number, sn_exp);
    wr(`CRS_ADDR_SN_LAST, {8'hc3}, 1);
    sn_exp[63:56] = 8'hc3;
    chk(serial_number, sn_exp);
    pt(8'h07, 1'b1);
    rd({sn_exp[55:48], 8'hc3, id_exp[31:24], id_exp[23:16], id_exp[15:8],
      id_exp[7:0], 8'h00, sn_exp[7:0]});
    wr(`CRS_ADDR_ID_FIRST, {8'hff, 8'h01}, 0);
    rd({id_exp[31:24]});
    pt(8'h20, 1'b0);
    fin();
    rd({id_exp[23:16]});
    wr(`CRS_ADDR_CMD, {8'h77}, 1);
    chk(save_req, 1'b0);
    rd({8'h00, sn_exp[7:0]});
    pt(`CRS_ADDR_CMD, 1'b1);
    rd({8'h00});
    power_fail = 1'b1;
    repeat (8) @(negedge clock);
    chk(save_req, 1'b0);
    power_fail = 1'b0;
    wr(`CRS_ADDR_MCTRL, {8'h03}, 1);
    chk({serial_lock_bit, memory_control}, 9'h103);
    wr(8'h02, {8'h99}, 0);
    chk(serial_number, sn_exp);
    rd({sn_exp[15:8]});
    wr(`CRS_ADDR_CMD, {`CRS_CMD_SAVE}, 1);
    wait_req(1'b1);
    sel(1'b1, 1'b0);
    fin();
    chk(target_busy, 1'b1);
    eng_en = 1'b1;
    wait_req(1'b0);
    eng_en = 1'b0;
    sel(1'b0, 1'b1);
    fin();
    power_fail = 1'b1;
    wait_req(1'b1);
    eng_en = 1'b1;
    wait_req(1'b0);
    power_fail = 1'b0;
    eng_en = 1'b0;
    results();
  end
  // Watchdog against a hung bus
  initial begin
    #2000000;
    miscompares++;
    results();
  end
endmodule
